// File: core/rmi_pkg.sv
// Shared constants and carriers for the radio MAC interrupt set/mask block
`default_nettype none

package rmi_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_IRQ_PENDING     = 8'hc0;
	localparam logic [7:0] OFS_IRQ_CLEAR       = 8'hc4;
	localparam logic [7:0] OFS_IRQ_FORCE       = 8'hc8;
	localparam logic [7:0] OFS_IRQ_ENABLE_MASK = 8'hcc;
	localparam logic [7:0] OFS_FIFO_THRESH     = 8'hd0;
	localparam logic [7:0] OFS_FRAME_PEND      = 8'hd4;

	// Source bit positions in the pending vector
	localparam int BIT_ACTION_STARTED  = 15;
	localparam int BIT_SYNC_DETECTED   = 14;
	localparam int BIT_COMPLETE_CLOCK  = 13;
	localparam int BIT_CRC_FAIL        = 12;
	localparam int BIT_FILTER_FAIL     = 11;
	localparam int BIT_SOFT_CLOCK      = 10;
	localparam int BIT_FIFO_THRESHOLD  = 9;
	localparam int BIT_RX_DONE         = 2;
	localparam int BIT_DATA_REQUEST    = 1;
	localparam int BIT_ACTION_COMPLETE = 0;

	// Implemented source bits; all others are reserved
	localparam logic [31:0] SRC_VALID_MASK = 32'h0000fe07;

	// Values after reset
	localparam logic [31:0] RST_IRQ_PENDING     = 32'h00000000;
	localparam logic [31:0] RST_IRQ_ENABLE_MASK = 32'h00000000;
	localparam int          FIFO_LVL_W          = 8;
	localparam logic [7:0]  RST_FIFO_THRESH     = 8'hff;
	localparam logic        RST_FRAME_PEND      = 1'b0;

	// Processor register port, one cycle per access
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} rmi_bus_t;

	// One-cycle event pulses from the rest of the accelerator
	typedef struct packed {
		logic action_started;
		logic sync_detected;
		logic complete_clock;
		logic crc_fail;
		logic filter_fail;
		logic soft_complete_clock;
		logic rx_done;
		logic data_request;
		logic action_complete;
	} rmi_evt_t;

endpackage

`default_nettype wire

// File: core/rmi_pend_bit.sv
// One sticky pending interrupt source bit
`default_nettype none

module rmi_pend_bit
(
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic event_i,
	input  wire logic force_i,
	input  wire logic clear_i,
	output logic      q_o
);
	import rmi_pkg::*;

	logic q_reg;
	logic q_next;

	// Set beats clear so an event in the clear cycle is kept
	always_comb
	begin
		q_next = (q_reg & ~clear_i) | event_i | force_i;
	end

	// Pending flop
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			q_reg <= 1'b0;
		else
			q_reg <= q_next;
	end

	assign q_o = q_reg;

endmodule

`default_nettype wire

// File: core/rmi_lvl_cmp.sv
// Rising-edge detector for the receive FIFO level against a threshold
`default_nettype none

module rmi_lvl_cmp
#(
	parameter int LVL_W = rmi_pkg::FIFO_LVL_W
)
(
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic [LVL_W-1:0] level_i,
	input  wire logic [LVL_W-1:0] thresh_i,
	output logic                  hit_o
);
	import rmi_pkg::*;

	logic at_or_above;
	logic above_reg;

	// Reached or exceeded
	assign at_or_above = (level_i >= thresh_i);

	// Previous comparison, so a level that stays high fires once
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			above_reg <= 1'b0;
		else
			above_reg <= at_or_above;
	end

	assign hit_o = at_or_above & ~above_reg;

endmodule

`default_nettype wire

// File: core/rmi_irq_top.sv
// Interrupt force, clear and enable logic of the radio MAC accelerator
//
// Overview of operation
// - Force write ORs written pattern into pending sources; zeros change nothing.
// - Bit 15 pends when an auto-sequence starts, immediate or timed.
// - Bit 14 pends when the modem detects a new incoming packet.
// - Bit 13 pends on complete clock trigger, bit 10 on soft one.
// - Bit 12 pends on checksum failure, bit 11 on filter rejection.
// - Bit 9 pends when receive FIFO level reaches or exceeds threshold.
// - Bit 2 pends when a packet is received successfully.
// - Bit 1 pends on data request; software may set frame pending.
// - Bit 0 pends when a whole auto-sequence has finished.
// - Interrupt raised only by pending sources whose enable bit is one.
// - Clear write inverts pattern and ANDs it into pending sources; an event in the same cycle wins.
`default_nettype none

module rmi_irq_top
#(
	parameter int LVL_W = rmi_pkg::FIFO_LVL_W
)
(
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire rmi_pkg::rmi_bus_t bus_i,
	output logic [31:0]           rdata_o,
	input  wire rmi_pkg::rmi_evt_t evt_i,
	input  wire logic [LVL_W-1:0] fifo_level_i,
	output logic                  irq_o,
	output logic                  frame_pending_o
);
	import rmi_pkg::*;

	logic [31:0]      src_evt;
	logic [31:0]      force_vec;
	logic [31:0]      clear_vec;
	logic [31:0]      pend;
	logic [31:0]      mask_reg;
	logic [LVL_W-1:0] thresh_reg;
	logic             frmpnd_reg;
	logic [31:0]      rdata_reg;
	logic [31:0]      rdata_next;
	logic             wr_force;
	logic             wr_clear;
	logic             wr_mask;
	logic             wr_thresh;
	logic             wr_frmpnd;
	logic             lvl_hit;

	// Write decode; unmapped writes fall through and do nothing
	assign wr_force  = bus_i.wr && (bus_i.addr == OFS_IRQ_FORCE);
	assign wr_clear  = bus_i.wr && (bus_i.addr == OFS_IRQ_CLEAR);
	assign wr_mask   = bus_i.wr && (bus_i.addr == OFS_IRQ_ENABLE_MASK);
	assign wr_thresh = bus_i.wr && (bus_i.addr == OFS_FIFO_THRESH);
	assign wr_frmpnd = bus_i.wr && (bus_i.addr == OFS_FRAME_PEND);

	// Force pattern, reserved positions dropped
	assign force_vec = wr_force ? (bus_i.wdata & SRC_VALID_MASK) : '0;
	// Clear pattern; force has no path to clear a bit
	assign clear_vec = wr_clear ? (bus_i.wdata & SRC_VALID_MASK) : '0;

	// FIFO threshold crossing, one pulse per crossing
	// Limitation: clearing the bit while the level stays high does not
	// re-arm it; the level must drop below the threshold first
	rmi_lvl_cmp #(
		.LVL_W    (LVL_W)
	) u_lvl (
		.clk_i    (clk_i),
		.rst_b_i  (rst_b_i),
		.level_i  (fifo_level_i),
		.thresh_i (thresh_reg),
		.hit_o    (lvl_hit)
	);

	// Hardware events mapped onto the source vector
	always_comb
	begin
		src_evt                      = '0;
		src_evt[BIT_ACTION_STARTED]  = evt_i.action_started;
		src_evt[BIT_SYNC_DETECTED]   = evt_i.sync_detected;
		src_evt[BIT_COMPLETE_CLOCK]  = evt_i.complete_clock;
		src_evt[BIT_SOFT_CLOCK]      = evt_i.soft_complete_clock;
		src_evt[BIT_CRC_FAIL]        = evt_i.crc_fail;
		src_evt[BIT_FILTER_FAIL]     = evt_i.filter_fail;
		src_evt[BIT_FIFO_THRESHOLD]  = lvl_hit;
		src_evt[BIT_RX_DONE]         = evt_i.rx_done;
		src_evt[BIT_DATA_REQUEST]    = evt_i.data_request;
		src_evt[BIT_ACTION_COMPLETE] = evt_i.action_complete;
	end

	// One sticky bit per implemented source; reserved bits stay zero
	for (genvar i = 0; i < 32; i++)
	begin : g_src
		if (SRC_VALID_MASK[i])
		begin : g_bit
			rmi_pend_bit u_bit (
				.clk_i   (clk_i),
				.rst_b_i (rst_b_i),
				.event_i (src_evt[i]),
				.force_i (force_vec[i]),
				.clear_i (clear_vec[i]),
				.q_o     (pend[i])
			);
		end
		else
		begin : g_rsv
			assign pend[i] = 1'b0;
		end
	end

	// Enable mask; reserved positions cannot be written
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			mask_reg <= RST_IRQ_ENABLE_MASK;
		else if (wr_mask)
			mask_reg <= bus_i.wdata & SRC_VALID_MASK;
	end

	// FIFO threshold; reset high so an empty FIFO does not fire
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			thresh_reg <= LVL_W'(RST_FIFO_THRESH);
		else if (wr_thresh)
			thresh_reg <= bus_i.wdata[LVL_W-1:0];
	end

	// Frame pending control for the fast reply to a data request
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			frmpnd_reg <= RST_FRAME_PEND;
		else if (wr_frmpnd)
			frmpnd_reg <= bus_i.wdata[0];
	end

	assign frame_pending_o = frmpnd_reg;

	// Read mux; write-only registers and holes read as zero
	always_comb
	begin
		rdata_next = '0;
		unique case (bus_i.addr)
			OFS_IRQ_PENDING:     rdata_next = pend;
			OFS_IRQ_ENABLE_MASK: rdata_next = mask_reg;
			OFS_FIFO_THRESH:     rdata_next = 32'(thresh_reg);
			OFS_FRAME_PEND:      rdata_next = {31'h0, frmpnd_reg};
			default:             rdata_next = '0;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			rdata_reg <= '0;
		else if (bus_i.rd)
			rdata_reg <= rdata_next;
		else
			rdata_reg <= '0;
	end

	assign rdata_o = rdata_reg;

	// Level output straight from flops; no extra latency on the line
	assign irq_o = |(pend & mask_reg);

	// Force sets every written source bit
	AST_FORCE_SETS: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		wr_force |=>
			((pend & $past(force_vec)) == $past(force_vec)))
		else $error("force write did not set its bits");

	// A force write never drops a pending bit
	AST_FORCE_NO_CLEAR: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		wr_force |=> ((pend & $past(pend)) == $past(pend)))
		else $error("force write cleared a pending bit");

	// Action started
	AST_ACTION_STARTED: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		evt_i.action_started |=> pend[15])
		else $error("action started not pending");

	// Sync detected
	AST_SYNC_DETECTED: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		evt_i.sync_detected |=> pend[14])
		else $error("sync detected not pending");

	// Both clock triggers
	AST_CLOCK_TRIGGERS: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(evt_i.complete_clock || evt_i.soft_complete_clock) |=>
			((pend[13] || !$past(evt_i.complete_clock)) &&
			 (pend[10] || !$past(evt_i.soft_complete_clock))))
		else $error("clock trigger not pending");

	// Checksum and filter failures
	AST_RX_FAILS: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(evt_i.crc_fail || evt_i.filter_fail) |=>
			((pend[12] || !$past(evt_i.crc_fail)) &&
			 (pend[11] || !$past(evt_i.filter_fail))))
		else $error("receive failure not pending");

	// Level crossing seen from the ports
	AST_FIFO_LEVEL: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		((fifo_level_i >= thresh_reg) &&
		 !$past(fifo_level_i >= thresh_reg)) |=> pend[9])
		else $error("fifo threshold not pending");

	// Data indication
	AST_RX_DONE: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		evt_i.rx_done |=> pend[2])
		else $error("rx done not pending");

	// Poll indication
	AST_DATA_REQUEST: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		evt_i.data_request |=> pend[1])
		else $error("data request not pending");

	// Action complete
	AST_ACTION_COMPLETE: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		evt_i.action_complete |=> pend[0])
		else $error("action complete not pending");

	// A bit only rises for its event or a force
	AST_NO_SPURIOUS: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		((pend & ~$past(pend)) & ~($past(src_evt) | $past(force_vec)))
			== 32'h0)
		else $error("pending bit rose without cause");

	// Masked-off sources keep the line low
	AST_MASK_GATES: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(wr_mask && (bus_i.wdata == 32'h0)) |=> !irq_o)
		else $error("interrupt with empty mask");

	// Enabling a pending source raises the line next cycle
	AST_MASK_ENABLE: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(wr_mask && !wr_clear && ((bus_i.wdata & pend) != 32'h0))
			|=> irq_o)
		else $error("enabled pending source gave no interrupt");

	// Clear drops the written bits unless an event hits them
	AST_CLEAR: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		wr_clear |=>
			(((pend & $past(clear_vec) & ~$past(src_evt)) == 32'h0)
			&& ((pend & ~$past(clear_vec)) ==
			    (($past(pend) | $past(src_evt))
			     & ~$past(clear_vec)))))
		else $error("clear write misbehaved");

	// Line holds until a clear or a mask change
	AST_IRQ_HOLD: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(irq_o && !wr_clear && !wr_mask) |=> irq_o [*1])
		else $error("interrupt dropped without clear");

	// Reserved positions never pend or read back
	AST_RESERVED: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		((pend & ~SRC_VALID_MASK) == 32'h0) &&
		((mask_reg & ~SRC_VALID_MASK) == 32'h0))
		else $error("reserved bit set");

	// Read answers in the following cycle only
	AST_READ_TIMING: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(bus_i.rd && (bus_i.addr == OFS_IRQ_ENABLE_MASK)) |=>
			(rdata_o == $past(mask_reg)) ##1
			(rdata_o == 32'h0 || $past(bus_i.rd)))
		else $error("mask read data wrong");

	// Force alone ORs in exactly the written pattern
	AST_FORCE_EXACT: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(wr_force && (src_evt == 32'h0)) |=>
			(pend == ($past(pend) | ($past(bus_i.wdata) & SRC_VALID_MASK))))
		else $error("force write result wrong");

	// Mask takes the written enables, reserved ones dropped
	AST_MASK_WRITE: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		wr_mask |=> (mask_reg == ($past(bus_i.wdata) & SRC_VALID_MASK)))
		else $error("mask write not taken");

	// Mask only moves on its own write
	AST_MASK_STEADY: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		!wr_mask |=> $stable(mask_reg))
		else $error("mask changed without write");

	// Line only rises after an event, a force or a mask write
	AST_IRQ_CAUSE: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		$rose(irq_o) |->
			$past(wr_mask || wr_force || (src_evt != 32'h0)))
		else $error("interrupt rose without cause");

	// Clearing every enabled pending bit drops the line
	AST_CLEAR_TO_IRQ: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(wr_clear && (src_evt == 32'h0) &&
		 ((pend & mask_reg & ~clear_vec) == 32'h0)) |=> !irq_o)
		else $error("interrupt held after clear");

	// Frame pending control follows its write
	AST_FRAME_PEND: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		wr_frmpnd |=> (frame_pending_o == $past(bus_i.wdata[0])))
		else $error("frame pending write not taken");

	// Read data fall back to zero without a read strobe
	AST_READ_IDLE: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		!bus_i.rd |=> (rdata_o == 32'h0))
		else $error("read data outside read cycle");

	// Pending status read returns the sticky bits
	AST_PEND_READ: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(bus_i.rd && (bus_i.addr == OFS_IRQ_PENDING)) |=>
			(rdata_o == $past(pend)))
		else $error("pending read data wrong");

endmodule

`default_nettype wire

// File: dv/rmi_cpu_model.sv
// Processor interrupt input model: counts entries into service
`default_nettype none

module rmi_cpu_model
(
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       irq_i,
	output logic [7:0]      rise_cnt_o
);
	timeunit 1ns;
	timeprecision 100ps;

	logic irq_reg;

	// Level input: one service entry per rise, held line is not recounted
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			irq_reg    <= 1'b0;
			rise_cnt_o <= 8'h00;
		end
		else
		begin
			irq_reg <= irq_i;
			if (irq_i && !irq_reg)
				rise_cnt_o <= rise_cnt_o + 8'h01;
		end
	end
endmodule

`default_nettype wire

// File: dv/radio_mac_irq_set_mask_bench.sv
// Self-checking bench for the interrupt force, clear and enable block
`default_nettype none

module radio_mac_irq_set_mask_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import rmi_pkg::*;

	logic        clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	rmi_bus_t    bus_i = '0;
	rmi_evt_t    evt_i = '0;
	logic [7:0]  fifo_level_i = 8'h00;
	logic [31:0] rdata_o;
	logic        irq_o;
	logic        frame_pending_o;
	logic [7:0]  rise_cnt;
	int          error_cnt = 0;
	int          compares = 0;
	int          pos [9] = '{0, 1, 2, 10, 11, 12, 13, 14, 15};

	always #12.5 clk_i = ~clk_i;

	rmi_irq_top dut
	(
		.clk_i           (clk_i),
		.rst_b_i         (rst_b_i),
		.bus_i           (bus_i),
		.rdata_o         (rdata_o),
		.evt_i           (evt_i),
		.fifo_level_i    (fifo_level_i),
		.irq_o           (irq_o),
		.frame_pending_o (frame_pending_o)
	);

	rmi_cpu_model cpu
	(
		.clk_i      (clk_i),
		.rst_b_i    (rst_b_i),
		.irq_i      (irq_o),
		.rise_cnt_o (rise_cnt)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
	begin
		compares++;
		if (seen !== exp)
		begin
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
			error_cnt++;
		end
	end
	endtask

	// One-cycle write strobe, dropped at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
	begin
		@(posedge clk_i);
		bus_i.wr    <= 1'b1;
		bus_i.addr  <= a;
		bus_i.wdata <= d;
		@(posedge clk_i);
		bus_i.wr    <= 1'b0;
		#1;
	end
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
	begin
		@(posedge clk_i);
		bus_i.rd   <= 1'b1;
		bus_i.addr <= a;
		@(posedge clk_i);
		bus_i.rd   <= 1'b0;
		#1;
		chk(rdata_o, exp);
		@(posedge clk_i);
		#1;
		chk(rdata_o, 32'h0);
	end
	endtask

	// Single event pulse on struct bit i
	task automatic ev(input int i);
	begin
		@(posedge clk_i);
		evt_i <= rmi_evt_t'(9'h001 << i);
		@(posedge clk_i);
		evt_i <= '0;
		#1;
	end
	endtask

	task automatic report_and_stop;
	begin
		if (error_cnt == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask

	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(OFS_IRQ_ENABLE_MASK, 32'h0);
		rd(OFS_IRQ_PENDING, 32'h0);
		chk({31'h0, irq_o}, 32'h0);
		// Force ORs in, zeros and reserved bits change nothing
		wr(OFS_IRQ_FORCE, 32'h00000001);
		rd(OFS_IRQ_PENDING, 32'h00000001);
		wr(OFS_IRQ_FORCE, 32'hffffffff);
		rd(OFS_IRQ_PENDING, 32'h0000fe07);
		wr(OFS_IRQ_FORCE, 32'h00000000);
		rd(OFS_IRQ_PENDING, 32'h0000fe07);
		rd(OFS_IRQ_FORCE, 32'h0);
		wr(OFS_IRQ_CLEAR, 32'h00000001);
		rd(OFS_IRQ_PENDING, 32'h0000fe06);
		wr(OFS_IRQ_CLEAR, 32'hffffffff);
		rd(OFS_IRQ_PENDING, 32'h0);
		wr(OFS_IRQ_ENABLE_MASK, 32'hffffffff);
		rd(OFS_IRQ_ENABLE_MASK, 32'h0000fe07);
		chk({31'h0, irq_o}, 32'h0);
		wr(OFS_IRQ_ENABLE_MASK, 32'h0);
		rd(8'h10, 32'h0);
		// Each event source except bit 9: pends masked, raises when enabled, drops on clear
		for (int i = 0; i < 9; i++)
		begin
			ev(i);
			rd(OFS_IRQ_PENDING, 32'h1 << pos[i]);
			chk({31'h0, irq_o}, 32'h0);
			wr(OFS_IRQ_ENABLE_MASK, 32'h1 << pos[i]);
			chk({31'h0, irq_o}, 32'h1);
			wr(OFS_IRQ_CLEAR, 32'h1 << pos[i]);
			chk({31'h0, irq_o}, 32'h0);
			wr(OFS_IRQ_ENABLE_MASK, 32'h0);
		end
		chk({24'h0, rise_cnt}, 32'h9);
		// Level reaching the threshold, not below it
		wr(OFS_FIFO_THRESH, 32'h10);
		rd(OFS_FIFO_THRESH, 32'h10);
		@(posedge clk_i);
		fifo_level_i <= 8'h0f;
		rd(OFS_IRQ_PENDING, 32'h0);
		@(posedge clk_i);
		fifo_level_i <= 8'h10;
		repeat (3) @(posedge clk_i);
		rd(OFS_IRQ_PENDING, 32'h00000200);
		wr(OFS_IRQ_CLEAR, 32'h00000200);
		// Event in the same cycle as its clear still sets the bit
		@(posedge clk_i);
		bus_i.wr    <= 1'b1;
		bus_i.addr  <= OFS_IRQ_CLEAR;
		bus_i.wdata <= 32'h1;
		evt_i.action_complete <= 1'b1;
		@(posedge clk_i);
		bus_i.wr <= 1'b0;
		evt_i    <= '0;
		rd(OFS_IRQ_PENDING, 32'h1);
		// Software answer to a data request
		wr(OFS_FRAME_PEND, 32'h1);
		chk({31'h0, frame_pending_o}, 32'h1);
		// Second reset in mid-run returns everything to zero except the threshold, which reads ff
		wr(OFS_IRQ_ENABLE_MASK, 32'h1);
		chk({31'h0, irq_o}, 32'h1);
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		#1;
		chk({31'h0, irq_o}, 32'h0);
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		#1;
		chk({30'h0, irq_o, frame_pending_o}, 32'h0);
		rd(OFS_IRQ_PENDING, 32'h0);
		rd(OFS_IRQ_ENABLE_MASK, 32'h0);
		rd(OFS_FIFO_THRESH, {24'h0, RST_FIFO_THRESH});
		report_and_stop();
	end
endmodule

`default_nettype wire
